// ==== hdl/pmc_pkg.sv ====
// constants for the power management capability register bank
package pmc_pkg;
  // dword address in config space holding the three items
  localparam logic [7:0] CAP_DWORD_ADDR = 8'hDC;
  // byte offsets of each item
  localparam logic [7:0] CAPABILITY_IDENTIFIER_OFFSET = 8'hDC;
  localparam logic [7:0] NEXT_PTR_OFFSET = 8'hDD;
  localparam logic [7:0] CAP_WORD_OFFSET = 8'hDE;
  // dword alignment: low address bits are the byte index
  localparam int ADDR_LSB = 2;
  // fixed item values
  localparam logic [7:0] CAPABILITY_IDENTIFIER_VALUE = 8'h01;
  localparam logic [7:0] NEXT_PTR_VALUE = 8'h00;
  localparam logic [4:0] EVENT_STATES_VALUE = 5'h09;
  localparam logic STATE_TWO_VALUE = 1'h0;
  localparam logic STATE_ONE_VALUE = 1'h0;
  localparam logic DEV_INIT_VALUE = 1'h0;
  localparam logic BUS_CLOCK_VALUE = 1'h0;
  localparam logic [2:0] VERSION_VALUE = 3'h2;
  // field positions within the capability word
  localparam int EVENT_STATES_MSB = 15;
  localparam int EVENT_STATES_LSB = 11;
  localparam int STATE_TWO_BIT = 10;
  localparam int STATE_ONE_BIT = 9;
  localparam int DEV_INIT_BIT = 5;
  localparam int BUS_CLOCK_BIT = 3;
  localparam int VERSION_MSB = 2;
  localparam int VERSION_LSB = 0;
  // event-capable state bits, lowest is D0
  localparam int EV_D0 = 0;
  localparam int EV_D1 = 1;
  localparam int EV_D2 = 2;
  localparam int EV_D3HOT = 3;
  localparam int EV_D3COLD = 4;
  // reserved positions within the capability word
  localparam int RSVD_MID_MSB = 8;
  localparam int RSVD_MID_LSB = 6;
  localparam int RSVD_BIT = 4;
  // byte lanes of the read data
  localparam int LANE_WIDTH = 8;
  localparam logic [7:0] LANE_ZERO = 8'h00;
  localparam logic [1:0] ID_LANE = CAPABILITY_IDENTIFIER_OFFSET[1:0];
  localparam logic [1:0] NEXT_LANE = NEXT_PTR_OFFSET[1:0];
  localparam logic [1:0] WORD_LO_LANE = CAP_WORD_OFFSET[1:0];
  localparam logic [1:0] WORD_HI_LANE = WORD_LO_LANE + 2'h1;
  // reset values of the read port
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// ==== hdl/pmc_cap_regs.sv ====
// power management capability items answering config reads
`timescale 1ns/10ps
module pmc_cap_regs (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // mode
  input wire logic i_satellite_mode,
  // config access request
  input wire logic i_cfg_req,
  input wire logic i_cfg_write,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  // config access answer
  output logic o_cfg_ack,
  output logic o_cfg_hit,
  output logic [31:0] o_cfg_rdata
);

  // event-capable states built bit by bit so each power state is visible
  function automatic logic [4:0] event_states();
    logic [4:0] ev;
    ev = '0;
    ev[pmc_pkg::EV_D0] = pmc_pkg::EVENT_STATES_VALUE[pmc_pkg::EV_D0];
    ev[pmc_pkg::EV_D1] = pmc_pkg::EVENT_STATES_VALUE[pmc_pkg::EV_D1];
    ev[pmc_pkg::EV_D2] = pmc_pkg::EVENT_STATES_VALUE[pmc_pkg::EV_D2];
    ev[pmc_pkg::EV_D3HOT] = pmc_pkg::EVENT_STATES_VALUE[pmc_pkg::EV_D3HOT];
    ev[pmc_pkg::EV_D3COLD] = pmc_pkg::EVENT_STATES_VALUE[pmc_pkg::EV_D3COLD];
    return ev;
  endfunction

  // reserved positions forced low one by one, so a stray field value cannot leak
  function automatic logic [15:0] clear_reserved(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    for (int i = pmc_pkg::RSVD_MID_LSB; i <= pmc_pkg::RSVD_MID_MSB; i++) begin
      r[i] = 1'b0;
    end
    r[pmc_pkg::RSVD_BIT] = 1'b0;
    return r;
  endfunction

  // capability word; unlisted bits stay zero as reserved
  function automatic logic [15:0] cap_word();
    logic [15:0] w;
    w = '0;
    w[pmc_pkg::EVENT_STATES_MSB:pmc_pkg::EVENT_STATES_LSB] = event_states();
    w[pmc_pkg::STATE_TWO_BIT] = pmc_pkg::STATE_TWO_VALUE;
    w[pmc_pkg::STATE_ONE_BIT] = pmc_pkg::STATE_ONE_VALUE;
    w[pmc_pkg::DEV_INIT_BIT] = pmc_pkg::DEV_INIT_VALUE;
    w[pmc_pkg::BUS_CLOCK_BIT] = pmc_pkg::BUS_CLOCK_VALUE;
    w[pmc_pkg::VERSION_MSB:pmc_pkg::VERSION_LSB] = pmc_pkg::VERSION_VALUE;
    return clear_reserved(w);
  endfunction

  // low byte of the capability word
  function automatic logic [7:0] word_low_byte();
    logic [15:0] w;
    w = cap_word();
    return w[pmc_pkg::LANE_WIDTH-1:0];
  endfunction

  // high byte of the capability word
  function automatic logic [7:0] word_high_byte();
    logic [15:0] w;
    w = cap_word();
    return w[2*pmc_pkg::LANE_WIDTH-1:pmc_pkg::LANE_WIDTH];
  endfunction

  // byte that one lane carries at the capability dword
  function automatic logic [7:0] lane_byte(input logic [1:0] lane);
    logic [7:0] b;
    b = pmc_pkg::LANE_ZERO;
    case (lane)
      pmc_pkg::ID_LANE: b = pmc_pkg::CAPABILITY_IDENTIFIER_VALUE;
      pmc_pkg::NEXT_LANE: b = pmc_pkg::NEXT_PTR_VALUE;
      pmc_pkg::WORD_LO_LANE: b = word_low_byte();
      pmc_pkg::WORD_HI_LANE: b = word_high_byte();
      default: b = pmc_pkg::LANE_ZERO;
    endcase
    return b;
  endfunction

  // a lane reads its byte only when enabled and the request is a hitting read
  function automatic logic [7:0] lane_read(input logic hit_rd, input logic en,
                                           input logic [1:0] lane);
    logic [7:0] b;
    b = pmc_pkg::LANE_ZERO;
    if (hit_rd && en) begin
      b = lane_byte(lane);
    end
    return b;
  endfunction

  logic next_ack;
  logic next_hit;
  logic [7:0] next_lane_id;
  logic [7:0] next_lane_next;
  logic [7:0] next_lane_lo;
  logic [7:0] next_lane_hi;
  logic [31:0] next_rdata;
  logic sel;
  logic rd_hit;

  // only config cycles in satellite mode hit this bank; every request is still acknowledged
  assign sel = i_satellite_mode &&
               (i_cfg_addr[7:pmc_pkg::ADDR_LSB] ==
                pmc_pkg::CAP_DWORD_ADDR[7:pmc_pkg::ADDR_LSB]);

  // writes are acknowledged but nothing is stored: all items are constants
  assign rd_hit = i_cfg_req && sel && !i_cfg_write;

  always_comb begin
    next_ack = i_cfg_req;
    next_hit = i_cfg_req && sel;
    next_lane_id = lane_read(rd_hit, i_cfg_be[pmc_pkg::ID_LANE], pmc_pkg::ID_LANE);
    next_lane_next = lane_read(rd_hit, i_cfg_be[pmc_pkg::NEXT_LANE], pmc_pkg::NEXT_LANE);
    next_lane_lo = lane_read(rd_hit, i_cfg_be[pmc_pkg::WORD_LO_LANE], pmc_pkg::WORD_LO_LANE);
    next_lane_hi = lane_read(rd_hit, i_cfg_be[pmc_pkg::WORD_HI_LANE], pmc_pkg::WORD_HI_LANE);
    next_rdata = {next_lane_hi, next_lane_lo, next_lane_next, next_lane_id};
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_cfg_ack <= 1'b0;
      o_cfg_hit <= 1'b0;
      o_cfg_rdata <= pmc_pkg::RDATA_RESET;
    end else begin
      o_cfg_ack <= next_ack;
      o_cfg_hit <= next_hit;
      o_cfg_rdata <= next_rdata;
    end
  end

endmodule

// ==== tb/pmc_host.sv ====
`timescale 1ns/10ps
// host issuing config slots
module pmc_host (input wire logic i_mclk, output logic o_req = 0, o_wr = 0,
  output logic [7:0] o_addr = 8'h00, output logic [3:0] o_be = 4'h0);
  // idle slots flip lines, no stale match
  task cyc(input logic r, w, input logic [7:0] a, input logic [3:0] b);
    o_req = r;
    o_wr = w;
    o_addr = r ? a : ~o_addr;
    o_be = r ? b : ~o_be;
    @(posedge i_mclk) #1;
  endtask
endmodule

// ==== tb/pmc_cap_regs_asserts.sv ====
`timescale 1ns/10ps
// bank port assertions
module pmc_cap_regs_asserts (input wire logic i_mclk, i_rstn, i_satellite_mode, i_cfg_req,
  i_cfg_write, o_cfg_ack, o_cfg_hit, input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be, input wire logic [31:0] o_cfg_rdata);
  wire q = i_cfg_req, s = i_satellite_mode;
  wire [31:0] d = o_cfg_rdata;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence hit_rd; q && s && !i_cfg_write && i_cfg_addr[7:2] == 6'h37; endsequence
  sequence rd; hit_rd ##0 i_cfg_be == 4'hF; endsequence
  sequence rd_lane_off; hit_rd ##0 !i_cfg_be[0]; endsequence
  lane_off_a: assert property (rd_lane_off |=> d[7:0] == 0) else $error("lane");
  capability_identifier_a: assert property (rd |=> d[15:0] == 16'h0001) else $error("id");
  event_set_a: assert property (rd |=> d[31:27] == 5'h09) else $error("ev");
  zero_bits_a: assert property (rd |=> d[26:19] == 0) else $error("z");
  version_a: assert property (rd |=> d[18:16] == 3'h2) else $error("v");
  dword_hit_a: assert property (rd |=> o_cfg_hit) else $error("h");
  write_nop_a: assert property (q && i_cfg_write |=> d == 0) else $error("w");
  wrong_mode_a: assert property (q && !s |=> !o_cfg_hit && d == 0) else $error("m");
  ack_slot_a: assert property (q |=> o_cfg_ack) else $error("a");
endmodule
bind pmc_cap_regs pmc_cap_regs_asserts chk_u (.*);

// ==== tb/test_pci_power_mgmt_capability.sv ====
`timescale 1ns/10ps
// random traffic checked against a model
`define CHK(n, e, s) n_tests++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end
module test_pci_power_mgmt_capability;
  logic i_mclk = 0, i_rstn = 0, i_satellite_mode = 0, i_cfg_req, i_cfg_write, h;
  logic o_cfg_ack, o_cfg_hit;
  logic [3:0] i_cfg_be, be;
  logic [31:0] mq[$], m;
  logic [15:0] w = {5'h09, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 3'h2};
  logic [7:0] i_cfg_addr;
  logic [31:0] o_cfg_rdata, e;
  int fails = 0, n_tests = 0, seed = 32'h105c;
  always #2 i_mclk = ~i_mclk;
  pmc_host host_u (.i_mclk, .o_req(i_cfg_req), .o_wr(i_cfg_write), .o_addr(i_cfg_addr),
    .o_be(i_cfg_be));
  pmc_cap_regs dut_u (.*);
  task give_verdict;
    $display("checks %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial #9000 begin
    fails++;
    give_verdict;
  end
  initial begin
    #63 i_rstn = 1;
    #4;
    repeat (600) begin
      i_satellite_mode = ($random(seed) & 7) != 0;
      be = $random(seed) & 1 ? 4'hF : 4'($random(seed));
      host_u.cyc(1'($random(seed)), 1'($random(seed)),
        $random(seed) & 1 ? 8'hDC : 8'($random(seed)), be);
      h = i_cfg_req && i_satellite_mode && i_cfg_addr[7:2] == 6'h37;
      e = h && !i_cfg_write ? {w, 8'h00, 8'h01} : 32'h0;
      for (int i = 0; i < 4; i++) if (!i_cfg_be[i]) e[i*8 +: 8] = 8'h00;
      mq.push_back(e);
      m = mq.pop_front();
      `CHK("ack", {i_cfg_req, h}, {o_cfg_ack, o_cfg_hit})
      `CHK("rdata", m, o_cfg_rdata)
    end
    i_rstn = 0;
    host_u.cyc(1'b1, 1'b0, 8'hDC, 4'hF);
    `CHK("reset", 34'h0, {o_cfg_ack, o_cfg_hit, o_cfg_rdata})
    i_rstn = 1;
    host_u.cyc(1'b0, 1'b0, 8'hDC, 4'hF);
    `CHK("release", 34'h0, {o_cfg_ack, o_cfg_hit, o_cfg_rdata})
    $display("traffic done");
    give_verdict;
  end
endmodule
